// ### hw/diag_flags_pkg.sv
package diag_flags_pkg;

    // bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int VAL_W  = 16;
    localparam int NQ     = 5;
    localparam int NTHR   = 4 * NQ;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS_CONTROL = 8'h6e;
    localparam logic [7:0] IDX_ALARM_HIGH     = 8'h70;
    localparam logic [7:0] IDX_ALARM_LOW      = 8'h71;
    localparam logic [7:0] IDX_WARNING_HIGH   = 8'h74;
    localparam logic [7:0] IDX_WARNING_LOW    = 8'h75;
    localparam logic [7:0] IDX_THR_BASE       = 8'h80;
    localparam logic [7:0] IDX_MEAS_BASE      = 8'ha0;

    // status/control field positions
    localparam int SC_PIN_OFF   = 7;
    localparam int SC_SOFT_OFF  = 6;
    localparam int SC_FAULT     = 2;
    localparam int SC_LOS       = 1;
    localparam int SC_NOT_READY = 0;

    // threshold slot within a quantity
    localparam int THR_HI_ALARM = 0;
    localparam int THR_LO_ALARM = 1;
    localparam int THR_HI_WARN  = 2;
    localparam int THR_LO_WARN  = 3;

    // quantity numbering
    localparam int Q_TEMP = 0;

    // reset values
    localparam logic [VAL_W-1:0] THR_HI_RST_S = 16'h7fff;
    localparam logic [VAL_W-1:0] THR_LO_RST_S = 16'h8000;
    localparam logic [VAL_W-1:0] THR_HI_RST_U = 16'hffff;
    localparam logic [VAL_W-1:0] THR_LO_RST_U = 16'h0000;
    localparam logic             SOFT_OFF_RST = 1'b0;

    // timing
    localparam longint CLK_HZ          = 50_000_000;
    localparam longint SOFT_RESP_MS    = 100;
    localparam longint SOFT_RESP_CYC   = SOFT_RESP_MS * CLK_HZ / 1000;
    localparam longint DATA_READY_MS   = 1000;
    localparam longint DATA_READY_CYC  = DATA_READY_MS * CLK_HZ / 1000;
    localparam int     READY_CNT_W     = 26;

endpackage

// ### hw/optical_module_diag_status_flags.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
// Summary of operation
// RULE_01: status bit 7 reads the live level of the transmitter-off pin.
// RULE_02: status bit 6 is a read/write software transmitter-off control.
// RULE_03: transmitter disabled when software bit or pin is asserted (OR).
// RULE_04: status bit 2 mirrors the transmitter fault output level.
// RULE_05: status bit 1 mirrors the receive signal lost output level.
// RULE_06: status bit 0 is active-low data ready; zero once valid measurements exist.
// RULE_07: soft commands take effect within 100 ms of the host write.
// RULE_08: measurement data becomes ready within 1000 ms after power-up.
// RULE_09: byte 112 bits 7/6 flag temperature above high / below low alarm.
// RULE_10: byte 112 bits 5/4 flag supply voltage above high / below low alarm.
// RULE_11: byte 112 bits 3/2 flag bias current above high / below low alarm.
// RULE_12: byte 112 bits 1/0 flag transmit power above high / below low alarm.
// RULE_13: byte 113 bits 7/6 flag receive power alarms; bits 0-5 reserved.
// RULE_14: byte 116 bits 7/6 flag temperature above high / below low warning.
// RULE_15: byte 116 bits 5/4 flag supply voltage warnings.
// RULE_16: byte 116 bits 3/2 flag bias current warnings.
// RULE_17: byte 116 bits 1/0 flag transmit power warnings.
// RULE_18: byte 117 bits 7/6 flag receive power warnings; bits 0-5 reserved.
// RULE_19: values and thresholds are 16 bit; temperature is signed two's complement.
// RULE_20: voltage, bias and powers are unsigned 16-bit counts compared directly.
// RULE_21: reserved bits read zero and ignore writes.
// RULE_22: flags recomputed on every monitoring update; clear when back in range.
module optical_module_diag_status_flags (
    input  wire logic                                     clk,                 // 50 MHz
    input  wire logic                                     resetn,              // async, active low
    input  wire logic [diag_flags_pkg::ADDR_W-1:0]        address,             // byte address
    input  wire logic                                     read,                // read request
    input  wire logic                                     write,               // write request
    input  wire logic [diag_flags_pkg::DATA_W-1:0]        writedata,           // write data
    input  wire logic [3:0]                               byteenable,          // byte lanes
    output logic      [diag_flags_pkg::DATA_W-1:0]        readdata,            // read data
    output logic                                          waitrequest,         // stall
    input  wire logic                                     transmitter_off_pin, // tx disable pin
    input  wire logic                                     transmitter_fault,   // fault output level
    input  wire logic                                     receive_signal_lost, // los output level
    input  wire logic                                     meas_valid,          // monitoring update
    input  wire logic [diag_flags_pkg::VAL_W-1:0]         meas_temp,           // signed temperature
    input  wire logic [diag_flags_pkg::VAL_W-1:0]         meas_vcc,            // supply voltage
    input  wire logic [diag_flags_pkg::VAL_W-1:0]         meas_bias,           // laser bias
    input  wire logic [diag_flags_pkg::VAL_W-1:0]         meas_txpwr,          // transmit power
    input  wire logic [diag_flags_pkg::VAL_W-1:0]         meas_rxpwr,          // receive power
    output logic                                          transmitter_disable, // effective disable
    output logic                                          sense_data_not_ready // active-low ready
);
    import diag_flags_pkg::*;

    logic                   rst_meta_ff;
    logic                   rst_n_ff;
    logic                   ack_ff;
    logic                   soft_off_ff;
    logic                   tx_dis_ff;
    logic                   not_ready_ff;
    logic [READY_CNT_W-1:0] ready_cnt_ff;
    logic [VAL_W-1:0]       thr_ff  [NTHR];
    logic [VAL_W-1:0]       meas_ff [NQ];
    logic [VAL_W-1:0]       meas_in [NQ];
    logic [2*NQ-1:0]        alarm_ff;
    logic [2*NQ-1:0]        warn_ff;
    logic [2*NQ-1:0]        nxt_alarm;
    logic [2*NQ-1:0]        nxt_warn;
    logic [DATA_W-1:0]      readdata_ff;
    logic [DATA_W-1:0]      nxt_readdata;
    logic [7:0]             idx;
    logic                   aligned;
    logic                   wr_take;
    logic [7:0]             status_byte;

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    assign idx     = address[9:2];
    assign aligned = (address[1:0] == 2'h0);

    // one wait state per access
    assign waitrequest = (read | write) & ~ack_ff;
    assign wr_take     = write & ack_ff;

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (read | write) & ~ack_ff;
        end
    end

    assign meas_in[0] = meas_temp;
    assign meas_in[1] = meas_vcc;
    assign meas_in[2] = meas_bias;
    assign meas_in[3] = meas_txpwr;
    assign meas_in[4] = meas_rxpwr;

    // software transmitter-off, low byte lane only
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            soft_off_ff <= SOFT_OFF_RST;
        end else if (wr_take && aligned && idx == IDX_STATUS_CONTROL && byteenable[0]) begin
            soft_off_ff <= writedata[SC_SOFT_OFF]; // see RULE_02 see RULE_07 see RULE_21
        end
    end

    // effective disable, one cycle after a pin change, two cycles after the write
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            tx_dis_ff <= 1'b0;
        end else begin
            tx_dis_ff <= soft_off_ff | transmitter_off_pin; // see RULE_03 see RULE_07
        end
    end
    assign transmitter_disable = tx_dis_ff;

    // data ready on first update, or forced at the power-up deadline
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            not_ready_ff <= 1'b1;
            ready_cnt_ff <= '0;
        end else if (not_ready_ff) begin
            ready_cnt_ff <= ready_cnt_ff + 1'b1;
            if (meas_valid || ready_cnt_ff == READY_CNT_W'(DATA_READY_CYC - 1)) begin
                not_ready_ff <= 1'b0; // see RULE_06 see RULE_08
            end
        end
    end
    assign sense_data_not_ready = not_ready_ff;

    // threshold storage and flag comparison per quantity
    genvar q;
    generate
        for (q = 0; q < NQ; q++) begin : g_q
            logic hi_a;
            logic lo_a;
            logic hi_w;
            logic lo_w;
            if (q == Q_TEMP) begin : g_s
                // signed compare for temperature
                assign hi_a = $signed(meas_in[q]) > $signed(thr_ff[4*q+THR_HI_ALARM]); // see RULE_19
                assign lo_a = $signed(meas_in[q]) < $signed(thr_ff[4*q+THR_LO_ALARM]);
                assign hi_w = $signed(meas_in[q]) > $signed(thr_ff[4*q+THR_HI_WARN]);
                assign lo_w = $signed(meas_in[q]) < $signed(thr_ff[4*q+THR_LO_WARN]);
            end else begin : g_u
                assign hi_a = meas_in[q] > thr_ff[4*q+THR_HI_ALARM]; // see RULE_20
                assign lo_a = meas_in[q] < thr_ff[4*q+THR_LO_ALARM];
                assign hi_w = meas_in[q] > thr_ff[4*q+THR_HI_WARN];
                assign lo_w = meas_in[q] < thr_ff[4*q+THR_LO_WARN];
            end
            // see RULE_09 see RULE_10 see RULE_11 see RULE_12 see RULE_13
            assign nxt_alarm[2*NQ-1-2*q] = hi_a;
            assign nxt_alarm[2*NQ-2-2*q] = lo_a;
            // see RULE_14 see RULE_15 see RULE_16 see RULE_17 see RULE_18
            assign nxt_warn[2*NQ-1-2*q]  = hi_w;
            assign nxt_warn[2*NQ-2-2*q]  = lo_w;

            always_ff @(posedge clk or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    meas_ff[q] <= '0;
                end else if (meas_valid) begin
                    meas_ff[q] <= meas_in[q];
                end
            end

            for (genvar t = 0; t < 4; t++) begin : g_t
                always_ff @(posedge clk or negedge rst_n_ff) begin
                    if (!rst_n_ff) begin
                        if (t == THR_HI_ALARM || t == THR_HI_WARN) begin
                            thr_ff[4*q+t] <= (q == Q_TEMP) ? THR_HI_RST_S : THR_HI_RST_U;
                        end else begin
                            thr_ff[4*q+t] <= (q == Q_TEMP) ? THR_LO_RST_S : THR_LO_RST_U;
                        end
                    end else if (wr_take && aligned && idx == IDX_THR_BASE + 8'(4*q+t)) begin
                        if (byteenable[1]) begin
                            thr_ff[4*q+t][15:8] <= writedata[15:8];
                        end
                        if (byteenable[0]) begin
                            thr_ff[4*q+t][7:0] <= writedata[7:0];
                        end
                    end
                end
            end
        end
    endgenerate

    // flags follow each update, clearing when back in range
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            alarm_ff <= '0;
            warn_ff  <= '0;
        end else if (meas_valid) begin
            alarm_ff <= nxt_alarm; // see RULE_22
            warn_ff  <= nxt_warn;
        end
    end

    assign status_byte = {transmitter_off_pin, soft_off_ff, 3'h0, // see RULE_01 see RULE_21
                          transmitter_fault, receive_signal_lost, not_ready_ff}; // see RULE_04 see RULE_05

    // read mux, unmapped reads return zero
    always_comb begin
        nxt_readdata = '0;
        if (aligned) begin
            if (idx == IDX_STATUS_CONTROL) begin
                nxt_readdata[7:0] = status_byte;
            end else if (idx == IDX_ALARM_HIGH) begin
                nxt_readdata[7:0] = alarm_ff[9:2];
            end else if (idx == IDX_ALARM_LOW) begin
                nxt_readdata[7:0] = {alarm_ff[1:0], 6'h00}; // see RULE_13 see RULE_21
            end else if (idx == IDX_WARNING_HIGH) begin
                nxt_readdata[7:0] = warn_ff[9:2];
            end else if (idx == IDX_WARNING_LOW) begin
                nxt_readdata[7:0] = {warn_ff[1:0], 6'h00}; // see RULE_18 see RULE_21
            end else if (idx >= IDX_THR_BASE && idx < IDX_THR_BASE + 8'(NTHR)) begin
                nxt_readdata[15:0] = thr_ff[5'(idx - IDX_THR_BASE)];
            end else if (idx >= IDX_MEAS_BASE && idx < IDX_MEAS_BASE + 8'(NQ)) begin
                nxt_readdata[15:0] = meas_ff[3'(idx - IDX_MEAS_BASE)];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            readdata_ff <= '0;
        end else if (read && !ack_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end
    assign readdata = readdata_ff;

endmodule

// ### sim/diag_flags_monitor.sv
`timescale 1ns/1ns
module diag_flags_monitor (
    input wire logic        clk,                  // clock
    input wire logic        resetn,               // reset
    input wire logic [9:0]  address,              // address
    input wire logic        read,                 // read
    input wire logic        write,                // write
    input wire logic [31:0] readdata,             // read data
    input wire logic        waitrequest,          // stall
    input wire logic        transmitter_off_pin,  // pin
    input wire logic        transmitter_fault,    // fault
    input wire logic        receive_signal_lost,  // los
    input wire logic        meas_valid,           // update
    input wire logic        transmitter_disable,  // disable
    input wire logic        sense_data_not_ready  // not ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic taken, stat_rd;
    assign taken   = read && !waitrequest;
    assign stat_rd = taken && address == 10'h1b8;
    chk_pin_disable: assert property (transmitter_off_pin |=> transmitter_disable)
        else $error("pin did not disable tx");
    chk_disable_cause: assert property ($rose(transmitter_disable) |-> $past(transmitter_off_pin)
        || $past(write && !waitrequest && address == 10'h1b8, 2)) else $error("tx disable without cause");
    chk_status_pin: assert property (stat_rd |-> readdata[7] == $past(transmitter_off_pin))
        else $error("status pin bit wrong");
    chk_status_lvls: assert property (stat_rd |->
        readdata[2:1] == {$past(transmitter_fault), $past(receive_signal_lost)}) else $error("status level wrong");
    chk_status_resv: assert property (stat_rd |-> readdata[5:3] == 3'h0 && readdata[31:8] == 24'h0)
        else $error("status reserved bits set");
    chk_flag_resv: assert property (taken && (address == 10'h1c4 || address == 10'h1d4) |->
        readdata[5:0] == 6'h0) else $error("flag reserved bits set");
    chk_ready_meas: assert property (meas_valid |=> !sense_data_not_ready)
        else $error("not ready after update");
    chk_ready_holds: assert property (!sense_data_not_ready |=> !sense_data_not_ready)
        else $error("ready dropped");
    cover property (stat_rd);
    cover property ($rose(transmitter_disable));
    cover property ($fell(sense_data_not_ready));
endmodule
bind optical_module_diag_status_flags diag_flags_monitor u_mon (.clk(clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .transmitter_off_pin(transmitter_off_pin), .transmitter_fault(transmitter_fault),
    .receive_signal_lost(receive_signal_lost), .meas_valid(meas_valid),
    .transmitter_disable(transmitter_disable), .sense_data_not_ready(sense_data_not_ready));

// ### sim/diag_host_model.sv
`timescale 1ns/1ns
module diag_host_model (
    input  wire logic        clk,         // clock
    input  wire logic [31:0] readdata,    // read data
    input  wire logic        waitrequest, // stall
    output logic      [9:0]  address,     // address
    output logic             read,        // read
    output logic             write,       // write
    output logic      [31:0] writedata,   // write data
    output logic      [3:0]  byteenable   // lanes
);
    initial {address, read, write, writedata, byteenable} = {10'h0, 2'b00, 32'h0, 4'hf};
    // one request, held until waitrequest samples low
    task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        address   <= a;
        writedata <= d;
        write     <= w;
        read      <= !w;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read      <= 1'b0;
        write     <= 1'b0;
        address   <= ~a;
        writedata <= ~d; // released bus stops showing old values
        @(posedge clk);
    endtask
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import diag_flags_pkg::*;
    logic             clk, resetn, pin, fault, los, mv, read, write, waitreq, tx_dis, not_rdy;
    logic [9:0]       address;
    logic [31:0]      wdata, rdata, q;
    logic [3:0]       be;
    logic [15:0]      mt, mo;
    int               mismatches, n_checks;
    logic [15:0]      thr [2][4] = '{'{16'h0100, 16'hff00, 16'h0080, 16'hff80},
                                     '{16'h9000, 16'h1000, 16'h8000, 16'h2000}};
    logic [15:0]      mset [4][2] = '{'{16'h0200, 16'ha000}, '{16'hfe00, 16'h0800},
                                      '{16'h00c0, 16'h8800}, '{16'h0000, 16'h5000}};
    logic [7:0]       eflg [4][2] = '{'{8'haa, 8'haa}, '{8'h55, 8'h55}, '{8'h00, 8'haa}, '{8'h00, 8'h00}};
    optical_module_diag_status_flags u_dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(wdata), .byteenable(be), .readdata(rdata), .waitrequest(waitreq),
        .transmitter_off_pin(pin), .transmitter_fault(fault), .receive_signal_lost(los), .meas_valid(mv),
        .meas_temp(mt), .meas_vcc(mo), .meas_bias(mo), .meas_txpwr(mo), .meas_rxpwr(~mo),
        .transmitter_disable(tx_dis), .sense_data_not_ready(not_rdy));
    diag_host_model u_host (.clk(clk), .readdata(rdata), .waitrequest(waitreq), .address(address), .read(read),
        .write(write), .writedata(wdata), .byteenable(be));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        u_host.xfer(a, 1'b0, 32'h0, q);
        check(q, exp);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test;
    end
    initial begin
        {resetn, pin, fault, los, mv, mt, mo} = {5'b00100, 32'h0};
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(10'h1b8, 32'h05);
        fault <= 1'b0;
        los   <= 1'b1;
        rd(10'h1b8, 32'h03);
        rd(10'h204, 32'h8000);
        rd(10'h210, 32'hffff);
        u_host.xfer(10'h1b8, 1'b1, 32'hff, q);
        rd(10'h1b8, 32'h43);
        check({31'h0, tx_dis}, 32'h1);
        u_host.xfer(10'h1b8, 1'b1, 32'h0, q);
        rd(10'h1b8, 32'h03);
        check({31'h0, tx_dis}, 32'h0);
        pin <= 1'b1;
        rd(10'h1b8, 32'h83);
        check({31'h0, tx_dis}, 32'h1);
        pin <= 1'b0;
        rd(10'h1bc, 32'h0);
        rd(10'h1b9, 32'h0);
        u_host.byteenable <= 4'he;
        u_host.xfer(10'h1b8, 1'b1, 32'h40, q);
        rd(10'h1b8, 32'h03);
        u_host.byteenable <= 4'h2;
        u_host.xfer(10'h200, 1'b1, 32'h1234, q);
        u_host.byteenable <= 4'hf;
        rd(10'h200, 32'h12ff);
        for (int i = 0; i < NQ * 4; i++) begin
            u_host.xfer(10'h200 + 10'(4 * i), 1'b1, {16'h0, thr[i / 4 != Q_TEMP][i % 4]}, q);
        end
        for (int k = 0; k < 4; k++) begin
            {mt, mo, mv} <= {mset[k][0], mset[k][1], 1'b1};
            @(posedge clk);
            mv <= 1'b0;
            rd(10'h1c0, {24'h0, eflg[k][0]});
            rd(10'h1c4, {24'h0, k[0], 7'h0});
            rd(10'h1d0, {24'h0, eflg[k][1]});
            rd(10'h1d4, {24'h0, k[0], 7'h0});
        end
        rd(10'h284, 32'h5000);
        rd(10'h290, 32'hafff);
        check({31'h0, not_rdy}, 32'h0);
        rd(10'h1b8, 32'h02);
        stop_test;
    end
endmodule
